// ---- hw/dac_rate_regs.vh ----
// register map, field positions, reset values and counts of the reset and rate core
// assumes it is included by bare name from the design files under hw/
//
// Function
// RL1 - three rate modes, from register or pins
// RL2 - codes 00 single, 01 dual, 10 quad
// RL3 - single rate: up to 54 kHz, 128x
// RL4 - dual rate: up to 108 kHz, 64x
// RL5 - quad rate: up to 216 kHz, 32x
// RL6 - host clock is 128 to 768 fs
// RL7 - host clock ratio matches the rate mode
// RL8 - after power-on, wait for clock activity; a reset pin rise in ST_HOLD starts initialization without it
// RL9 - every initialization lasts 1024 clock periods
// RL10 - audio accepted only after initialization
// RL11 - software mode: registers defaulted during initialization
// RL12 - outputs muted through reset and initialization
// RL13 - reset pin active low, rise starts initialization
// RL14 - soft reset bit starts identical sequence
// RL15 - pin low 65536 cycles enters power-down
// RL16 - soft reset bit clears itself at start
`ifndef DAC_RATE_REGS_VH
`define DAC_RATE_REGS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CTRL_OFF 12'h000
`define STAT_OFF 12'h004
`define INFO_OFF 12'h008

// ****************************************
// control register fields
// ****************************************
`define CTRL_RATE_LSB 0
`define CTRL_RATE_MSB 1
`define CTRL_SRST_BIT 2
`define CTRL_RATE_RST 2'h0

// ****************************************
// status register fields
// ****************************************
`define STAT_STATE_LSB 0
`define STAT_DONE_BIT 3
`define STAT_MUTE_BIT 4
`define STAT_PDN_BIT 5
`define STAT_BAD_BIT 6
`define STAT_CLK_BIT 7
`define STAT_SWMODE_BIT 8
`define STAT_RATE_LSB 12

// ****************************************
// info register fields
// ****************************************
`define INFO_OSR_LSB 0
`define INFO_FSMAX_LSB 8
`define INFO_FSMIN_LSB 16

// ****************************************
// rate codes and their figures
// ****************************************
`define RATE_SINGLE 2'h0
`define RATE_DUAL 2'h1
`define RATE_QUAD 2'h2
`define OSR_SINGLE 8'h80
`define OSR_DUAL 8'h40
`define OSR_QUAD 8'h20
`define FSMAX_SINGLE 8'h36
`define FSMAX_DUAL 8'h6c
`define FSMAX_QUAD 8'hd8
`define FSMIN_SINGLE 8'h00

// ****************************************
// timing counts in sys_clk_in cycles
// ****************************************
`define INIT_LAST 10'h3ff
`define PDN_CYCLES_DEF 17'h1_0000

// ****************************************
// synchroniser reset: reset pin idles high
// ****************************************
`define SYNC_W 5
`define SYNC_RST_VAL 5'h10

`endif

// ---- hw/dac_reset_and_rate_control.v ----
// reset sequencer and sample-rate selector of a four-channel converter core
// assumes an apb3 master on sys_clk_in; configuration pins, the reset pin
// and the host's master clock arrive unsynchronised
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dac_rate_regs.vh"

module dac_reset_and_rate_control #(
    parameter [16:0] PDN_CYCLES = `PDN_CYCLES_DEF
) (
    input wire sys_clk_in,
    input wire srst_in,
    input wire ce_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire rst_pin_n_in,
    input wire sw_mode_pin_in,
    input wire rate_pin_low_in,
    input wire rate_pin_high_in,
    input wire master_clk_in,
    output wire mute_out,
    output wire audio_accept_out,
    output wire reg_clear_out,
    output wire clk_stop_out,
    output wire [1:0] rate_mode_out,
    output wire [7:0] osr_out
);

    // ****************************************
    // states
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_INIT = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_HOLD = 3'h3;
    localparam [2:0] ST_PDOWN = 3'h4;

    localparam [16:0] PDN_LAST = PDN_CYCLES - 17'h1;

    // ****************************************
    // declarations
    // ****************************************
    wire [`SYNC_W-1:0] pins_s;
    wire rstn_s;
    wire sw_mode_s;
    wire rate_hi_s;
    wire rate_lo_s;
    wire mclk_s;
    reg mclk_d_r;
    reg rstn_d_r;
    wire mclk_edge;
    wire rstn_rise;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [9:0] init_cnt_r;
    reg [16:0] pdn_cnt_r;
    wire init_start;
    wire init_restart;

    reg [1:0] ctrl_rate_r;
    reg srst_req_r;
    reg clk_seen_r;
    reg done_r;

    wire [1:0] rate_code;
    wire [7:0] dec_osr;
    wire [7:0] dec_fsmax;
    wire [7:0] dec_fsmin;
    wire dec_valid;
    reg [1:0] rate_r;
    reg [7:0] osr_r;
    reg [7:0] fsmax_r;
    reg [7:0] fsmin_r;
    reg rate_bad_r;

    reg mute_r;
    reg accept_r;
    reg clear_r;
    reg stop_r;

    reg [31:0] prdata_r;
    reg pready_r;
    reg pslverr_r;
    reg [31:0] rd_mux;
    reg rd_hit;
    wire access;
    wire wr_ctrl;

    // ****************************************
    // pin synchronisers
    // ****************************************
    pin_sync2 #(
        .W(`SYNC_W),
        .RST_VAL(`SYNC_RST_VAL)
    ) u_sync (
        .clk_in(sys_clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .d_in({rst_pin_n_in, sw_mode_pin_in, rate_pin_high_in,
               rate_pin_low_in, master_clk_in}),
        .q_out(pins_s)
    );

    assign rstn_s = pins_s[4];
    assign sw_mode_s = pins_s[3];
    assign rate_hi_s = pins_s[2];
    assign rate_lo_s = pins_s[1];
    assign mclk_s = pins_s[0];

    // edge detectors look only at synchronised levels
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            mclk_d_r <= 1'b0;
            rstn_d_r <= 1'b1;
        end else if (ce_in) begin
            mclk_d_r <= mclk_s;
            rstn_d_r <= rstn_s;
        end
    end

    // the master clock is sampled, so activity means any toggle seen;
    // a master clock near or above half sys_clk_in may alias
    assign mclk_edge = mclk_s ^ mclk_d_r;
    assign rstn_rise = rstn_s & ~rstn_d_r; // RL13

    // ****************************************
    // sequencer
    // ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (!rstn_s) begin
                    state_nxt = ST_HOLD;
                end else if (mclk_edge) begin
                    state_nxt = ST_INIT; // RL8
                end
            end
            ST_INIT: begin
                if (!rstn_s) begin
                    state_nxt = ST_HOLD;
                end else if (init_cnt_r == `INIT_LAST && !srst_req_r) begin
                    state_nxt = ST_RUN; // RL9
                end
            end
            ST_RUN: begin
                if (!rstn_s) begin
                    state_nxt = ST_HOLD;
                end else if (srst_req_r) begin
                    state_nxt = ST_INIT; // RL14
                end
            end
            ST_HOLD: begin
                if (rstn_rise) begin
                    state_nxt = ST_INIT; // RL13
                end else if (pdn_cnt_r == PDN_LAST) begin
                    state_nxt = ST_PDOWN; // RL15
                end
            end
            ST_PDOWN: begin
                // host restarts its clock before raising the pin
                if (rstn_rise) begin
                    state_nxt = ST_INIT; // RL15
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // a soft reset during initialization restarts the count from zero
    assign init_restart = (state_r == ST_INIT) && rstn_s && srst_req_r; // RL14
    assign init_start = ((state_nxt == ST_INIT) && (state_r != ST_INIT))
                        || init_restart;

    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_r <= ST_IDLE;
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            init_cnt_r <= 10'h000;
        end else if (ce_in) begin
            if (init_start) begin
                init_cnt_r <= 10'h000;
            end else if (state_r == ST_INIT) begin
                init_cnt_r <= init_cnt_r + 10'h001; // RL9
            end
        end
    end

    // counts the cycles the pin has been seen low
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            pdn_cnt_r <= 17'h0_0000;
        end else if (ce_in) begin
            if (state_r == ST_HOLD && pdn_cnt_r != PDN_LAST) begin
                pdn_cnt_r <= pdn_cnt_r + 17'h0_0001; // RL15
            end else if (state_r != ST_HOLD) begin
                pdn_cnt_r <= 17'h0_0000;
            end
        end
    end

    // ****************************************
    // control register
    // ****************************************
    assign access = psel_in & penable_in;
    // writes land on the edge where the master sees pready high
    assign wr_ctrl = access & pready_r & pwrite_in & (paddr_in == `CTRL_OFF);

    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            ctrl_rate_r <= `CTRL_RATE_RST;
        end else if (ce_in) begin
            if (state_r == ST_INIT && sw_mode_s) begin
                ctrl_rate_r <= `CTRL_RATE_RST; // RL11
            end else if (wr_ctrl) begin
                ctrl_rate_r <= pwdata_in[`CTRL_RATE_MSB:`CTRL_RATE_LSB]; // RL1
            end
        end
    end

    // a new request written in the cycle the old one is consumed survives
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            srst_req_r <= 1'b0;
        end else if (ce_in) begin
            if (wr_ctrl && sw_mode_s && pwdata_in[`CTRL_SRST_BIT]) begin
                srst_req_r <= 1'b1; // RL14
            end else if (init_start) begin
                srst_req_r <= 1'b0; // RL16
            end
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            clk_seen_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce_in) begin
            if (mclk_edge) begin
                clk_seen_r <= 1'b1;
            end
            if (init_start || state_nxt != ST_RUN) begin
                done_r <= 1'b0;
            end else if (state_r == ST_INIT) begin
                done_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // rate selection
    // ****************************************
    assign rate_code = sw_mode_s ? ctrl_rate_r : {rate_hi_s, rate_lo_s}; // RL1

    rate_decode u_dec (
        .code_in(rate_code),
        .osr_out(dec_osr),
        .fs_max_out(dec_fsmax),
        .fs_min_out(dec_fsmin),
        .valid_out(dec_valid)
    );

    // the clock ratio against fs is the host's duty and is not checked here
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            rate_r <= `RATE_SINGLE;
            osr_r <= `OSR_SINGLE;
            fsmax_r <= `FSMAX_SINGLE;
            fsmin_r <= `FSMIN_SINGLE;
            rate_bad_r <= 1'b0;
        end else if (ce_in) begin
            rate_r <= rate_code; // RL1
            osr_r <= dec_osr; // RL2
            fsmax_r <= dec_fsmax;
            fsmin_r <= dec_fsmin;
            rate_bad_r <= ~dec_valid; // RL2
        end
    end

    // ****************************************
    // sequencer outputs
    // ****************************************
    // registered from the next state so they line up with state_r
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            mute_r <= 1'b1;
            accept_r <= 1'b0;
            clear_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (ce_in) begin
            mute_r <= (state_nxt != ST_RUN); // RL12
            accept_r <= (state_nxt == ST_RUN); // RL10
            clear_r <= (state_nxt == ST_INIT) && sw_mode_s; // RL11
            stop_r <= (state_nxt == ST_PDOWN); // RL15
        end
    end

    // ****************************************
    // apb read path
    // ****************************************
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr_in)
            `CTRL_OFF: begin
                rd_mux[`CTRL_RATE_MSB:`CTRL_RATE_LSB] = ctrl_rate_r;
                rd_mux[`CTRL_SRST_BIT] = srst_req_r;
            end
            `STAT_OFF: begin
                rd_mux[`STAT_STATE_LSB+2:`STAT_STATE_LSB] = state_r;
                rd_mux[`STAT_DONE_BIT] = done_r;
                rd_mux[`STAT_MUTE_BIT] = mute_r;
                rd_mux[`STAT_PDN_BIT] = stop_r;
                rd_mux[`STAT_BAD_BIT] = rate_bad_r;
                rd_mux[`STAT_CLK_BIT] = clk_seen_r;
                rd_mux[`STAT_SWMODE_BIT] = sw_mode_s;
                rd_mux[`STAT_RATE_LSB+1:`STAT_RATE_LSB] = rate_r;
            end
            `INFO_OFF: begin
                rd_mux[`INFO_OSR_LSB+7:`INFO_OSR_LSB] = osr_r;
                rd_mux[`INFO_FSMAX_LSB+7:`INFO_FSMAX_LSB] = fsmax_r;
                rd_mux[`INFO_FSMIN_LSB+7:`INFO_FSMIN_LSB] = fsmin_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            if (access && !pready_r) begin
                pready_r <= 1'b1;
                pslverr_r <= ~rd_hit;
                prdata_r <= pwrite_in ? 32'h0000_0000 : rd_mux;
            end else begin
                pready_r <= 1'b0;
                pslverr_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign mute_out = mute_r;
    assign audio_accept_out = accept_r;
    assign reg_clear_out = clear_r;
    assign clk_stop_out = stop_r;
    assign rate_mode_out = rate_r;
    assign osr_out = osr_r;

endmodule
`default_nettype wire

// ---- hw/pin_sync2.v ----
// two-stage synchroniser for a group of unrelated level pins
// assumes one clock, synchronous active-high reset and a clock enable
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clk_in,
    input wire srst_in,
    input wire ce_in,
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);

    reg [W-1:0] meta_r;
    reg [W-1:0] q_r;

    // meta_r feeds q_r only; nothing else may look at it
    always @(posedge clk_in) begin
        if (srst_in) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else if (ce_in) begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end

    assign q_out = q_r;

endmodule
`default_nettype wire

// ---- hw/rate_decode.v ----
// decodes a two-bit rate code into oversampling ratio and fs window
// assumes a combinational consumer that registers the results
`timescale 1ns/1ps
`default_nettype none
`include "dac_rate_regs.vh"

module rate_decode (
    input wire [1:0] code_in,
    output reg [7:0] osr_out,
    output reg [7:0] fs_max_out,
    output reg [7:0] fs_min_out,
    output reg valid_out
);

    always @* begin
        osr_out = `OSR_SINGLE;
        fs_max_out = `FSMAX_SINGLE;
        fs_min_out = `FSMIN_SINGLE;
        valid_out = 1'b1;
        case (code_in)
            `RATE_SINGLE: begin
                osr_out = `OSR_SINGLE; // RL3
                fs_max_out = `FSMAX_SINGLE; // RL3
            end
            `RATE_DUAL: begin
                osr_out = `OSR_DUAL; // RL4
                fs_max_out = `FSMAX_DUAL; // RL4
                fs_min_out = `FSMAX_SINGLE; // RL4
            end
            `RATE_QUAD: begin
                osr_out = `OSR_QUAD; // RL5
                fs_max_out = `FSMAX_QUAD; // RL5
                fs_min_out = `FSMAX_DUAL; // RL5
            end
            default: begin
                // unused code: run as single rate but flag it
                valid_out = 1'b0; // RL2
            end
        endcase
    end

endmodule
`default_nettype wire

// ---- sim/dac_host_model.sv ----
// host controller model: master clock, reset pin and configuration pins
// assumes the bench commands it on the rising edge of sys_clk_in
`timescale 1ns/1ps
`default_nettype none

module dac_host_model (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic clk_run_in,
    input wire logic rst_n_cmd_in,
    input wire logic sw_cmd_in,
    input wire logic [1:0] rate_cmd_in,
    output var logic master_clk_out,
    output var logic rst_pin_n_out,
    output var logic sw_mode_out,
    output var logic rate_pin_low_out,
    output var logic rate_pin_high_out
);
    // ****************************************
    // clock and pins
    // ****************************************
    logic [1:0] div_r;

    // one eighth of sys_clk keeps the level sampler honest; the fs ratio is
    // not observable by this block, so any legal multiple serves
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            div_r <= 2'h0;
            master_clk_out <= 1'b0;
        end else if (clk_run_in) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) begin
                master_clk_out <= ~master_clk_out;
            end
        end
    end

    always @(posedge sys_clk_in) begin
        rst_pin_n_out <= srst_in | rst_n_cmd_in;
        sw_mode_out <= sw_cmd_in;
        rate_pin_low_out <= rate_cmd_in[0];
        rate_pin_high_out <= rate_cmd_in[1];
    end
endmodule
`default_nettype wire

// ---- sim/dac_reset_and_rate_control_bench.sv ----
// self-checking bench of the reset sequencer and rate selector
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "dac_rate_regs.vh"
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end

module dac_reset_and_rate_control_bench;
    logic sys_clk_in, srst_in, ce_in, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic run, rst_cmd, sw, err;
    logic [1:0] rate;
    logic mclk, rst_pin_n, sw_pin, rpl, rph, mute, accept, clr, stop;
    logic [1:0] rmode;
    logic [7:0] osr;
    int fails, n_tests, n;
    logic [7:0] osr_t [4] = '{8'h80, 8'h40, 8'h20, 8'h80};
    logic [31:0] info_t [3] = '{32'h0000_3680, 32'h0036_6c40, 32'h006c_d820};

    dac_reset_and_rate_control #(.PDN_CYCLES(17'h0_0010)) uut (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rst_pin_n_in(rst_pin_n),
        .sw_mode_pin_in(sw_pin), .rate_pin_low_in(rpl), .rate_pin_high_in(rph),
        .master_clk_in(mclk), .mute_out(mute), .audio_accept_out(accept), .reg_clear_out(clr),
        .clk_stop_out(stop), .rate_mode_out(rmode), .osr_out(osr));

    dac_host_model host (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in), .clk_run_in(run), .rst_n_cmd_in(rst_cmd),
        .sw_cmd_in(sw), .rate_cmd_in(rate), .master_clk_out(mclk), .rst_pin_n_out(rst_pin_n),
        .sw_mode_out(sw_pin), .rate_pin_low_out(rpl), .rate_pin_high_out(rph));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // master holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk_in);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            fails++;
            finish_test();
        end
    endtask

    // counts init cycles from the first cycle of register clear to accept
    task automatic wait_init();
        int k;
        k = 0;
        n = 0;
        while (clr !== 1'b1 && k < 50) begin
            @(posedge sys_clk_in);
            #1 k++;
        end
        while (accept !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_in);
            #1 n++;
        end
        if (k >= 50 || n >= 3000) begin
            fails++;
            finish_test();
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fails = 0;
        n_tests = 0;
        {srst_in, ce_in, rst_cmd, sw} = 4'hf;
        {psel, penable, pwrite, run} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        rate = 2'h0;
        repeat (3) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        repeat (40) @(posedge sys_clk_in);
        #1 `CHECK({mute, accept, clr}, 3'h4)
        apb(1'b0, `STAT_OFF, 32'h0000_0000);
        `CHECK(rd, 32'h0000_0110)
        apb(1'b0, `CTRL_OFF, 32'h0000_0000);
        `CHECK(rd, 32'h0000_0000)
        run <= 1'b1;
        wait_init();
        `CHECK(n, 1024)
        `CHECK(mute, 1'b0)
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `CTRL_OFF, 32'(c));
            repeat (3) @(posedge sys_clk_in);
            #1 `CHECK(rmode, 2'(c))
            `CHECK(osr, osr_t[c])
            apb(1'b0, (c < 3) ? `INFO_OFF : `STAT_OFF, 32'h0000_0000);
            `CHECK(rd, (c < 3) ? info_t[c] : 32'h0000_31ca)
        end
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        `CHECK(err, 1'b1)
        apb(1'b0, 12'h00c, 32'h0000_0000);
        `CHECK({err, rd}, 33'h1_0000_0000)
        sw <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            rate <= 2'(c);
            repeat (8) @(posedge sys_clk_in);
            #1 `CHECK({rmode, osr}, {2'(c), osr_t[c]})
            @(posedge sys_clk_in);
        end
        // a frozen core must ignore the new pin code
        ce_in <= 1'b0;
        rate <= 2'h1;
        repeat (8) @(posedge sys_clk_in);
        #1 `CHECK({rmode, osr}, {2'h3, 8'h80})
        @(posedge sys_clk_in);
        ce_in <= 1'b1;
        sw <= 1'b1;
        rate <= 2'h0;
        apb(1'b1, `CTRL_OFF, 32'h0000_0006);
        wait_init();
        `CHECK(n, 1024)
        apb(1'b0, `CTRL_OFF, 32'h0000_0000);
        `CHECK(rd, 32'h0000_0000)
        @(posedge sys_clk_in);
        rst_cmd <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
        #1 `CHECK({mute, accept, stop}, 3'h4)
        @(posedge sys_clk_in);
        rst_cmd <= 1'b1;
        wait_init();
        `CHECK(n, 1024)
        @(posedge sys_clk_in);
        rst_cmd <= 1'b0;
        repeat (40) @(posedge sys_clk_in);
        #1 `CHECK({mute, stop}, 2'h3)
        @(posedge sys_clk_in);
        rst_cmd <= 1'b1;
        wait_init();
        `CHECK({stop, n}, {1'b0, 32'd1024})
        finish_test();
    end
endmodule
`default_nettype wire

// ---- sim/dac_reset_and_rate_control_properties.sv ----
// port checker of the reset sequencer and rate selector
// assumes it is bound onto dac_reset_and_rate_control, one clock domain
`timescale 1ns/1ps
`default_nettype none

module dac_reset_and_rate_control_checker #(
    parameter [16:0] PDN_CYCLES = 17'h1_0000
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic rst_pin_n_in,
    input wire logic sw_mode_pin_in,
    input wire logic master_clk_in,
    input wire logic mute_out,
    input wire logic audio_accept_out,
    input wire logic reg_clear_out,
    input wire logic clk_stop_out,
    input wire logic [1:0] rate_mode_out,
    input wire logic [7:0] osr_out
);
    // ****************************************
    // helper counters
    // ****************************************
    localparam int INIT_CYCLES = 1024;
    int clr_cnt_r;
    int low_cnt_r;
    logic seen_r;
    logic mclk_q_r;

    // saturate so a long power-down cannot wrap the count
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            clr_cnt_r <= 0;
            low_cnt_r <= 0;
            seen_r <= 1'b0;
            mclk_q_r <= master_clk_in;
        end else begin
            clr_cnt_r <= reg_clear_out ? clr_cnt_r + 1 : 0;
            low_cnt_r <= rst_pin_n_in ? 0 : (low_cnt_r < 100000 ? low_cnt_r + 1 : low_cnt_r);
            seen_r <= seen_r | (master_clk_in != mclk_q_r);
            mclk_q_r <= master_clk_in;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    a_mute_vs_accept: assert property (mute_out != audio_accept_out)
        else $error("mute and accept not complementary");
    a_osr_decode: assert property (osr_out == (rate_mode_out == 2'h1 ? 8'h40 : (rate_mode_out == 2'h2 ? 8'h20 : 8'h80)))
        else $error("osr does not match rate code");
    a_init_length: assert property ($rose(audio_accept_out) && sw_mode_pin_in |-> clr_cnt_r == INIT_CYCLES)
        else $error("initialization length wrong");
    a_clear_muted: assert property (reg_clear_out |-> mute_out && !audio_accept_out)
        else $error("register clear outside muted init");
    a_stop_muted: assert property (clk_stop_out |-> mute_out && !reg_clear_out)
        else $error("power-down not muted");
    a_pdown_time: assert property ($rose(clk_stop_out) |-> low_cnt_r >= PDN_CYCLES && low_cnt_r <= PDN_CYCLES + 8)
        else $error("power-down entered at wrong time");
    a_pin_low_mutes: assert property (!rst_pin_n_in [*5] |-> mute_out && !reg_clear_out)
        else $error("reset pin low did not hold mute");
    a_rise_starts: assert property ($rose(rst_pin_n_in) && sw_mode_pin_in |-> ##[1:5] reg_clear_out)
        else $error("pin release did not start init");
    a_idle_no_clock: assert property (!seen_r |-> !reg_clear_out && !audio_accept_out)
        else $error("init started without clock activity");
    a_apb_one_wait: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
        else $error("apb answer not after one wait state");
endmodule

bind dac_reset_and_rate_control dac_reset_and_rate_control_checker #(.PDN_CYCLES(PDN_CYCLES)) chk_i (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pready_out(pready_out),
    .rst_pin_n_in(rst_pin_n_in),
    .sw_mode_pin_in(sw_mode_pin_in),
    .master_clk_in(master_clk_in),
    .mute_out(mute_out),
    .audio_accept_out(audio_accept_out),
    .reg_clear_out(reg_clear_out),
    .clk_stop_out(clk_stop_out),
    .rate_mode_out(rate_mode_out),
    .osr_out(osr_out)
);
`default_nettype wire
